//--- psu_dev_model.sv
// Behavioural two-wire device: identity memory plus measurement converter
`timescale 1ns/1ps
`default_nettype none
module psu_dev_model
  import psu_mon_pkg::*;
#(
  parameter logic [2:0] STRAP = 3'h7
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] chan [4];
  logic [7:0] sh, ptr, last, setup;
  logic [3:0] bitn;
  logic [1:0] ch;
  logic       act, rd, nak, hit, conv;
  int         nb;

  // Idle and released until a start shows up
  initial begin
    sda_oe = 0;
    act = 0;
    last = 8'h5A;
    ptr = 8'h00;
  end

  // Start or repeated start restarts byte framing
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1;
    bitn = 4'hF;
    nb = 0;
    rd = 0;
    nak = 0;
    hit = 0;
  end

  // Stop ends the transfer
  always @(posedge sda) if (scl === 1'b1) act = 0;

  // Shift in written bits, catch the master's answer after a read byte
  always @(posedge scl) if (act) begin
    if (!rd) sh = {sh[6:0], sda};
    else if (bitn == 4'h8) nak = sda;
  end

  // Drive only while clock is low so data never moves under a high clock
  always @(negedge scl) if (act) begin
    bitn = bitn + 4'h1;
    if (bitn == 4'h8) begin
      if (!rd) begin
        if (nb == 0) begin
          hit = sh[3:1] == STRAP && (sh[7:4] == ID_PREFIX || sh[7:4] == ADC_PREFIX);
          conv = sh[7:4] == ADC_PREFIX;
          rd = sh[0] && hit;
        end else if (conv) begin
          setup = sh;
          ch = sh[1:0];
          last = ~last;  // Stale byte is the complement of the byte last held
        end else begin
          ptr = sh;
        end
        sda_oe = hit;
        nb++;
      end else begin
        sda_oe = 0;
      end
    end else if (bitn == 4'h9) begin
      bitn = 4'h0;
      sda_oe = 0;
      if (rd && !nak) begin
        if (conv) begin
          sh = last;
          last = chan[ch];
          if (setup[SETUP_AUTOINC_BIT]) ch = ch + 2'h1;
        end else begin
          sh = mem[ptr];
          ptr = ptr + 8'h01;
        end
        sda_oe = !sh[7];
      end
    end else if (rd && !nak) begin
      sda_oe = !sh[4'h7 - bitn];
    end
  end
endmodule
`default_nettype wire

//--- psu_i2c_engine.sv
// Open-drain bus engine: start, stop, byte write and byte read with ack
`timescale 1ns/1ps
`default_nettype none
module psu_i2c_engine
  import psu_mon_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  tick,
  psu_i2c_if.eng     bus,
  input  wire logic  sda_in,
  output logic       scl_oe,
  output logic       sda_oe
);
  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} eng_state_type;

  typedef struct packed {
    eng_state_type st;
    logic [1:0]    ph;
    logic [3:0]    bit_n;
    logic [8:0]    sh;
    logic          scl_oe;
    logic          sda_oe;
    logic          done;
    logic          nack;
    logic [7:0]    rdata;
  } eng_type;

  eng_type s;
  eng_type next_s;

  // Each bus step takes four ticks; the ninth bit is the acknowledge slot
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      E_IDLE: begin
        if (bus.cmd_valid) begin
          next_s.ph    = 2'h0;
          next_s.bit_n = 4'h0;
          next_s.sh    = (bus.cmd == CMD_READ) ? {8'hFF, !bus.ack_out} : {bus.wdata, 1'b1};
          case (bus.cmd)
            CMD_START: next_s.st = E_START;
            CMD_STOP:  next_s.st = E_STOP;
            default:   next_s.st = E_BIT;
          endcase
        end
      end
      E_START: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: next_s.sda_oe = 1'b0;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b1; // Data falls while clock high
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.st     = E_IDLE;
              next_s.done   = 1'b1;
            end
          endcase
        end
      end
      E_BIT: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: next_s.sda_oe = !s.sh[8];
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: begin
              if (s.bit_n == 4'h8) begin
                next_s.nack = sda_in; // Released line means no acknowledge
              end else begin
                next_s.rdata = {s.rdata[6:0], sda_in};
              end
            end
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.sh     = {s.sh[7:0], 1'b0};
              next_s.bit_n  = s.bit_n + 4'h1;
              if (s.bit_n == 4'h8) begin
                next_s.st   = E_IDLE;
                next_s.done = 1'b1;
              end
            end
          endcase
        end
      end
      E_STOP: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: next_s.sda_oe = 1'b1;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b0; // Data rises while clock high
            default: begin
              next_s.st   = E_IDLE;
              next_s.done = 1'b1;
            end
          endcase
        end
      end
      default: next_s.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign scl_oe    = s.scl_oe;
  assign sda_oe    = s.sda_oe;
  assign bus.done  = s.done;
  assign bus.nack  = s.nack;
  assign bus.rdata = s.rdata;
  assign bus.busy  = (s.st != E_IDLE);
endmodule
`default_nettype wire

//--- psu_i2c_if.sv
// Command link between the transfer sequencer and the byte engine
`timescale 1ns/1ps
`default_nettype none
interface psu_i2c_if;
  import psu_mon_pkg::*;
  logic        cmd_valid;
  i2c_cmd_type cmd;
  logic [7:0]  wdata;
  logic        ack_out;
  logic        done;
  logic [7:0]  rdata;
  logic        nack;
  logic        busy;
  modport seq (output cmd_valid, cmd, wdata, ack_out, input done, rdata, nack, busy);
  modport eng (input cmd_valid, cmd, wdata, ack_out, output done, rdata, nack, busy);
endinterface
`default_nettype wire

//--- psu_mon_pkg.sv
// Shared constants and types for the supply monitor host controller
package psu_mon_pkg;
  // Timing: system clock and serial bus rate
  localparam int CLK_HZ      = 200_000_000;
  localparam int SCL_HZ      = 100_000;
  localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
  // Slave address prefixes, upper four bits
  localparam logic [3:0] ID_PREFIX  = 4'h A;
  localparam logic [3:0] ADC_PREFIX = 4'h9;
  // Converter setup byte layout
  localparam int         SETUP_AUTOINC_BIT = 6;
  localparam int         SETUP_MODE_BIT    = 2;
  localparam logic [7:0] SETUP_SCAN        = 8'h44;
  localparam logic [1:0] CH_VOLT           = 2'h0;
  localparam logic [1:0] CH_CURR           = 2'h1;
  localparam logic [1:0] CH_TEMP           = 2'h2;
  // Reads per transfer, first converter byte is stale
  localparam logic [2:0] SCAN_READS   = 3'h4;
  localparam logic [2:0] SINGLE_READS = 3'h2;
  localparam logic [2:0] ID_READS     = 3'h1;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_ID_DATA = 8'h08;
  localparam logic [7:0] REG_RAW     = 8'h0C;
  localparam logic [7:0] REG_VOLT    = 8'h10;
  localparam logic [7:0] REG_CURR    = 8'h14;
  localparam logic [7:0] REG_TEMP    = 8'h18;
  // Control register fields
  localparam int          CTRL_GO       = 0;
  localparam int          CTRL_OP       = 1;
  localparam int          CTRL_SCAN     = 2;
  localparam int          CTRL_CH_LO    = 4;
  localparam int          CTRL_STRAP_LO = 8;
  localparam int          CTRL_MODEL_LO = 12;
  localparam int          CTRL_OFS_LO   = 16;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0700;
  // Scale per count: volts in 0.1 mV, amps in 0.1 mA, degrees in 1 mC
  localparam logic [11:0] VOLT_RES [4] = '{12'h24A, 12'h493, 12'h61B, 12'h928};
  localparam logic [11:0] CURR_RES [4] = '{12'hC30, 12'h7A1, 12'h7A1, 12'h3D1};
  localparam logic [11:0] TEMP_RES     = 12'h187;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Byte engine commands
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} i2c_cmd_type;
endpackage

//--- psu_monitor_host.sv
// Supply monitor host: register slave, transfer sequencer and result scaling
//
// Behaviour
// - Identity memory address is 1010, straps, direction
// - Converter address is 1001, straps, direction
// - Setup byte written first, reserved bits zero
// - Single read: flags clear, channel code low
// - Both flags set, channel zero: scan all
// - First byte of each converter read run discarded
// - Quantity equals raw byte times resolution
// - Voltage resolution per model range
// - Current resolution per model range
// - Temperature resolution same for every model
// - Strap bit zero when tied, one open
// - Serial clock runs at 100 kHz
`timescale 1ns/1ps
`default_nettype none
module psu_monitor_host
  import psu_mon_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_ADDR_W, S_SUB, S_RSTART, S_ADDR_R, S_READ, S_STOP
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    aw_a;
    logic [31:0]   w_d;
    logic [3:0]    w_s;
    logic          awready;
    logic          wready;
    logic          arready;
    logic          bvalid;
    logic          rvalid;
    logic [1:0]    bresp;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [31:0]   ctrl;
    logic          busy;
    logic          done;
    logic          err;
    logic          cmd_valid;
    i2c_cmd_type   cmd;
    logic [7:0]    wbyte;
    logic          ack_out;
    logic          issued;
    logic [2:0]    rd_cnt;
    logic [7:0]    id_data;
    logic [23:0]   raw;
    logic [19:0]   volt;
    logic [19:0]   curr;
    logic [19:0]   temp;
    logic          pin_low;
  } host_type;

  host_type s;
  host_type next_s;

  psu_i2c_if link ();
  logic      tick;

  // Control fields, decoded once
  logic       op;
  logic       scan;
  logic [1:0] ch;
  logic [2:0] strap;
  logic [1:0] model;
  logic [3:0] prefix;
  logic [7:0] setup;
  logic [2:0] reads;
  assign op     = s.ctrl[CTRL_OP];
  assign scan   = s.ctrl[CTRL_SCAN];
  assign ch     = s.ctrl[CTRL_CH_LO +: 2];
  assign strap  = s.ctrl[CTRL_STRAP_LO +: 3];
  assign model  = s.ctrl[CTRL_MODEL_LO +: 2];
  assign prefix = op ? ADC_PREFIX : ID_PREFIX;
  assign setup  = scan ? SETUP_SCAN : {6'h00, ch};
  assign reads  = !op ? ID_READS : (scan ? SCAN_READS : SINGLE_READS);

  psu_tick_gen #(
    .QUARTER (QUARTER)
  ) u_tick (
    .clock (clock),
    .nrst  (nrst),
    .run   (link.busy),
    .tick  (tick)
  );

  psu_i2c_engine u_eng (
    .clock  (clock),
    .nrst   (nrst),
    .tick   (tick),
    .bus    (link),
    .sda_in (sda_in),
    .scl_oe (scl_oe),
    .sda_oe (sda_oe)
  );

  // Register read view; unmapped offsets read zero with an error answer
  function automatic logic [32:0] read_reg(input logic [7:0] a, input host_type h);
    case (a)
      REG_CTRL:    read_reg = {1'b0, h.ctrl};
      REG_STATUS:  read_reg = {1'b0, 29'h0000_0000, h.err, h.done, h.busy};
      REG_ID_DATA: read_reg = {1'b0, 24'h00_0000, h.id_data};
      REG_RAW:     read_reg = {1'b0, 8'h00, h.raw};
      REG_VOLT:    read_reg = {1'b0, 12'h000, h.volt};
      REG_CURR:    read_reg = {1'b0, 12'h000, h.curr};
      REG_TEMP:    read_reg = {1'b0, 12'h000, h.temp};
      default:     read_reg = {1'b1, 32'h0000_0000};
    endcase
  endfunction

  // Bus slave, then sequencer; one next-state copy for the whole block
  always_comb begin
    logic [32:0] rd;
    logic [1:0]  idx;
    rd  = read_reg(araddr, s);
    idx = scan ? 2'(s.rd_cnt - 3'h1) : ch;
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.pin_low   = 1'b0;
    // Address and data may arrive in either order
    if (s.awready && awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_a   = awaddr;
    end
    if (s.wready && wvalid) begin
      next_s.w_got = 1'b1;
      next_s.w_d   = wdata;
      next_s.w_s   = wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = (s.aw_a == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      // Control is frozen while a transfer runs, so fields stay coherent
      if (s.aw_a == REG_CTRL && !s.busy) begin
        for (int i = 0; i < 4; i++) begin
          if (s.w_s[i]) begin
            next_s.ctrl[8*i +: 8] = s.w_d[8*i +: 8];
          end
        end
        next_s.ctrl[CTRL_GO] = 1'b0;
        if (s.w_s[0] && s.w_d[CTRL_GO]) begin
          next_s.busy = 1'b1;
          next_s.done = 1'b0;
          next_s.err  = 1'b0;
          next_s.st   = S_START;
        end
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.arready && arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd[31:0];
      next_s.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    // Issue one engine command per state, one per byte in S_READ, then wait for its completion
    if (s.st != S_IDLE && !s.issued) begin
      next_s.cmd_valid = 1'b1;
      next_s.issued    = 1'b1;
      next_s.ack_out   = 1'b0;
      next_s.wbyte     = 8'h00;
      case (s.st)
        S_START, S_RSTART: next_s.cmd = CMD_START;
        S_ADDR_W: begin
          next_s.cmd   = CMD_WRITE;
          next_s.wbyte = {prefix, strap, 1'b0};
        end
        S_SUB: begin
          next_s.cmd   = CMD_WRITE;
          next_s.wbyte = op ? setup : s.ctrl[CTRL_OFS_LO +: 8];
        end
        S_ADDR_R: begin
          next_s.cmd   = CMD_WRITE;
          next_s.wbyte = {prefix, strap, 1'b1};
        end
        S_READ: begin
          next_s.cmd     = CMD_READ;
          next_s.ack_out = (s.rd_cnt != reads - 3'h1); // Last byte is not acknowledged
        end
        default: next_s.cmd = CMD_STOP;
      endcase
    end else if (link.done) begin
      next_s.issued = 1'b0;
      case (s.st)
        S_START:  next_s.st = S_ADDR_W;
        S_RSTART: next_s.st = S_ADDR_R;
        S_ADDR_W, S_SUB, S_ADDR_R: begin
          // A missing acknowledge aborts with a stop condition
          if (link.nack) begin
            next_s.err = 1'b1;
            next_s.st  = S_STOP;
          end else begin
            next_s.st     = (s.st == S_ADDR_W) ? S_SUB : (s.st == S_SUB) ? S_RSTART : S_READ;
            next_s.rd_cnt = 3'h0;
          end
        end
        S_READ: begin
          if (!op) begin
            next_s.id_data = link.rdata;
          end else if (s.rd_cnt != 3'h0 && idx != 2'h3) begin
            next_s.raw[{idx, 3'h0} +: 8] = link.rdata;
          end
          next_s.rd_cnt = s.rd_cnt + 3'h1;
          if (s.rd_cnt == reads - 3'h1) begin
            next_s.st = S_STOP;
          end
        end
        default: begin
          next_s.st   = S_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          // Scaling is a plain product, the converter being linear from zero
          next_s.volt = 20'(s.raw[7:0] * VOLT_RES[model]);
          next_s.curr = 20'(s.raw[15:8] * CURR_RES[model]);
          next_s.temp = 20'(s.raw[23:16] * TEMP_RES);
        end
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s      <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Engine command link and outputs, all taken from the state register
  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd       = s.cmd;
  assign link.wdata     = s.wbyte;
  assign link.ack_out   = s.ack_out;
  assign awready        = s.awready;
  assign wready         = s.wready;
  assign arready        = s.arready;
  assign bvalid         = s.bvalid;
  assign bresp          = s.bresp;
  assign rvalid         = s.rvalid;
  assign rresp          = s.rresp;
  assign rdata          = s.rdata;
  assign scl_out        = s.pin_low;
  assign sda_out        = s.pin_low;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_id_addr;
    (s.cmd_valid && s.st == S_ADDR_W && !op) |-> s.wbyte == {ID_PREFIX, strap, 1'b0};
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("identity address wrong");

  property p_adc_addr;
    (s.cmd_valid && s.st == S_ADDR_R && op) |-> s.wbyte == {ADC_PREFIX, strap, 1'b1};
  endproperty
  a_adc_addr: assert property (p_adc_addr) else $error("converter address wrong");

  property p_setup_fmt;
    (s.cmd_valid && s.st == S_SUB && op) |-> !s.wbyte[7] && s.wbyte[5:3] == 3'h0;
  endproperty
  a_setup_fmt: assert property (p_setup_fmt) else $error("setup reserved bits set");

  property p_single;
    (s.cmd_valid && s.st == S_SUB && op && !scan)
      |-> !s.wbyte[SETUP_AUTOINC_BIT] && !s.wbyte[SETUP_MODE_BIT] && s.wbyte[1:0] == ch;
  endproperty
  a_single: assert property (p_single) else $error("single setup wrong");

  property p_scan;
    (s.cmd_valid && s.st == S_SUB && op && scan) |-> s.wbyte == SETUP_SCAN ##1 !s.cmd_valid;
  endproperty
  a_scan: assert property (p_scan) else $error("scan setup wrong");

  property p_discard;
    (link.done && !s.issued && s.st == S_READ && op && s.rd_cnt == 3'h0) |=> $stable(s.raw);
  endproperty
  a_discard: assert property (p_discard) else $error("stale byte stored");

  property p_scale;
    (link.done && !s.issued && s.st == S_STOP)
      |=> s.volt == 20'(s.raw[7:0] * VOLT_RES[model]) && s.done && !s.busy;
  endproperty
  a_scale: assert property (p_scale) else $error("voltage scaling wrong");

  property p_rvalid_hold;
    (s.rvalid && !rready) |=> s.rvalid && $stable(s.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");

  c_id_done:   cover property (link.done && s.st == S_STOP && !op && !s.err);
  c_scan_done: cover property (link.done && s.st == S_STOP && op && scan && !s.err);
  c_nack:      cover property (s.err && !s.busy);
endmodule
`default_nettype wire

//--- psu_monitor_i2c_readout_tb.sv
// Self-checking bench for the supply monitor host controller
`timescale 1ns/1ps
`default_nettype none
module psu_monitor_i2c_readout_tb;
  import psu_mon_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic        clock = 0, nrst = 0;
  logic [7:0]  awaddr = 0, araddr = 0, seed = 8'h29;
  logic [7:0]  img [256];
  logic [7:0]  raw [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h14, 8'h68, 8'hFE, 8'hFF};
  logic [31:0] wdata = 0, got, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, dev_oe;
  logic [1:0]  bresp, rresp;
  logic [65:0] e;
  logic [65:0] exp_r [$];
  logic [1:0]  exp_b [$];
  int          vres [4] = '{586, 1171, 1563, 2344};
  int          cres [4] = '{3120, 1953, 1953, 977};
  int          n_fail = 0, checked = 0, cyc = 0;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || dev_oe);

  psu_monitor_host #(.QUARTER(10)) dut (
    .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe
  );
  psu_dev_model #(.STRAP(STRAP)) dev (.scl, .sda, .sda_oe(dev_oe));

  always #2.5 clock = !clock;

  function automatic logic [7:0] lfsr();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  // Control word: go, op, scan, channel, straps, model, identity offset
  function automatic logic [31:0] ctl(input logic op, sc, input logic [1:0] c,
                                      input logic [2:0] s, input logic [1:0] m,
                                      input logic [7:0] o);
    return {8'h00, o, 2'h0, m, 1'h0, s, 2'h0, c, 1'h0, sc, op, 1'h1};
  endfunction

  task automatic cmp(input logic [33:0] g, input logic [33:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask

  // Mask zero turns a read into a poll whose value is not judged
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, x, input logic [1:0] er);
    @(posedge clock);
    exp_r.push_back({m, er, x & m});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    got = rdata;
    rready <= 0;
  endtask

  task automatic run(input logic [31:0] c);
    int k;
    k = 0;
    wr(REG_CTRL, c, RESP_OKAY);
    do begin
      rdx(REG_STATUS, 32'h0, 32'h0, RESP_OKAY);
      k++;
    end while (got[0] !== 1'b0 && k < 4000);
  endtask

  // Answer watcher: each answer is paired with the oldest note
  always @(posedge clock) begin
    if (rvalid && rready) begin
      e = exp_r.pop_front();
      cmp({rresp, rdata & e[65:34]}, e[33:0]);
    end
    if (bvalid && bready) cmp({32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  // Watchdog against a hung transfer
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      img[i] = lfsr();
      dev.mem[i] = img[i];
    end
    repeat (12) @(posedge clock);
    nrst <= 1;
    repeat (2) @(posedge clock);
    // Register map corners
    rdx(REG_CTRL, 32'hFFFF_FFFF, CTRL_RESET, RESP_OKAY);
    rdx(8'h1C, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    wr(REG_STATUS, 32'h0, RESP_SLVERR);
    // Identity bytes at field starts and the top byte
    foreach (ofs[i]) begin
      run(ctl(0, 0, 2'h0, STRAP, 2'h0, ofs[i]));
      rdx(REG_ID_DATA, 32'hFFFF_FFFF, {24'h0, img[ofs[i]]}, RESP_OKAY);
    end
    // Single channel reads, one per channel code
    for (int c = 0; c < 3; c++) begin
      raw[c] = lfsr();
      dev.chan[c] = raw[c];
      run(ctl(1, 0, c[1:0], STRAP, 2'h0, 8'h00));
      rdx(REG_RAW, 32'hFFFF_FFFF, {8'h0, raw[2], raw[1], raw[0]}, RESP_OKAY);
    end
    // Scan of all channels under each model's scaling, full scale included
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 3; j++) raw[j] = (m == 3) ? 8'hFF : lfsr();
      for (int j = 0; j < 3; j++) dev.chan[j] = raw[j];
      run(ctl(1, 1, 2'h0, STRAP, m[1:0], 8'h00));
      rdx(REG_RAW, 32'hFFFF_FFFF, {8'h0, raw[2], raw[1], raw[0]}, RESP_OKAY);
      rdx(REG_VOLT, 32'hFFFF_FFFF, 32'(raw[0] * vres[m]), RESP_OKAY);
      rdx(REG_CURR, 32'hFFFF_FFFF, 32'(raw[1] * cres[m]), RESP_OKAY);
      rdx(REG_TEMP, 32'hFFFF_FFFF, 32'(raw[2] * 391), RESP_OKAY);
    end
    // Foreign strap: nobody answers, raw bytes stay
    run(ctl(1, 1, 2'h0, 3'h2, 2'h0, 8'h00));
    rdx(REG_STATUS, 32'h0000_0006, 32'h0000_0006, RESP_OKAY);
    rdx(REG_RAW, 32'hFFFF_FFFF, {8'h0, raw[2], raw[1], raw[0]}, RESP_OKAY);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- psu_tick_gen.sv
// Quarter bit period enable for the serial bus
`timescale 1ns/1ps
`default_nettype none
module psu_tick_gen
  import psu_mon_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic run,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_type;

  tick_type s;
  tick_type next_s;

  // Divider restarts whenever the engine is idle so every command starts clean
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 16'h0000;
    end else if (s.cnt == 16'(QUARTER - 1)) begin
      next_s.cnt  = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  property p_tick_gap;
    @(posedge clock) disable iff (!nrst) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("bus tick too fast");
endmodule
`default_nettype wire
